// file: hw/se_pkg.sv
// constants, types and helpers for the two-wire memory bus master
package se_pkg;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int BIT_PERIOD_NS  = 10000;
  localparam int QUARTER_CYC    = BIT_PERIOD_NS / CLK_PERIOD_NS / 4;
  localparam int WRITE_CYCLE_NS = 5000000;
  localparam int POLL_BITS      = 11;
  localparam int POLL_LIMIT     = WRITE_CYCLE_NS / (BIT_PERIOD_NS * POLL_BITS)
                                  + 1;
  localparam logic [3:0] ACK_BIT    = 4'h8;
  localparam logic [3:0] LAST_BIT   = 4'h7;
  localparam logic [2:0] PAGE_LAST  = 3'h3;
  localparam logic       DIR_READ   = 1'b1;
  localparam logic       DIR_WRITE  = 1'b0;
  localparam int         BYTE_W     = 8;

  typedef enum logic [1:0] {
    OP_WRITE, OP_RAND_READ, OP_CUR_READ, OP_POLL
  } se_op_t;
  typedef enum logic [1:0] {
    PH_SETUP, PH_RISE, PH_SAMPLE, PH_FALL
  } se_phase_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_XMIT, ST_RECV, ST_STOP
  } se_stage_t;
  typedef enum logic [2:0] {
    SG_ADDR, SG_WORD, SG_DATA, SG_RADDR, SG_READ
  } se_seg_t;

  // len is byte count minus one; wdata bits [7:0] go out first
  typedef struct packed {
    se_op_t      op;
    logic [2:0]  strap;
    logic [7:0]  word;
    logic [2:0]  len;
    logic [31:0] wdata;
  } se_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } se_rd_t;

  function automatic logic [7:0] slave_byte(input logic [3:0] code,
                                            input logic [2:0] strap,
                                            input logic       dir);
    slave_byte = {code, strap, dir};
  endfunction
endpackage

// file: hw/se_sync3.sv
// three-stage synchroniser for the data line, two-stage agreement
module se_sync3
  import se_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic d_i,
  output logic      q_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } se_sync_t;

  se_sync_t st_reg;
  se_sync_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.q;
endmodule

// file: hw/se_tick.sv
// divider that pulses once per quarter of a serial bit
module se_tick
  import se_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output logic      tick_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } se_div_t;

  localparam logic [15:0] TOP = 16'(QUARTER - 1);

  se_div_t st_reg;
  se_div_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == TOP) begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick;
endmodule

// file: hw/se_host.sv
// two-wire bus master that writes, reads and polls the serial memory
module se_host
  import se_pkg::*;
#(
  parameter int         QUARTER  = QUARTER_CYC,
  parameter int         POLL_MAX = POLL_LIMIT,
  parameter logic [3:0] DEV_TYPE = 4'h5  // value is arbitrary
) (
  input  wire logic     clk_i,
  input  wire logic     rstn_i,
  input  wire logic     cmd_valid_i,
  input  wire se_cmd_t  cmd_i,
  output logic          cmd_ready_o,
  output se_rd_t        rd_o,
  output logic          done_o,
  output logic          nack_o,
  output logic          scl_o,
  input  wire logic     sda_i,
  output logic          sda_o,
  output logic          sda_oe_o,
  output logic          write_inhibit_o
);
  //////////////////////////////////////////////////////////////////////////
  // reset release, bus sampling and bit timing
  logic rs1_reg;
  logic rst_n;
  logic sda_s;
  logic tick;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rs1_reg <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_n   <= rs1_reg;
    end
  end

  se_sync3 u_sync (
    .clk_i  (clk_i),
    .rstn_i (rst_n),
    .d_i    (sda_i),
    .q_o    (sda_s)
  );

  se_tick #(.QUARTER(QUARTER)) u_tick (
    .clk_i  (clk_i),
    .rstn_i (rst_n),
    .tick_o (tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    se_stage_t   stage;
    se_seg_t     seg;
    se_phase_t   ph;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [2:0]  left;
    se_cmd_t     cmd;
    logic [7:0]  polls;
    logic        ackd;
    logic        fail;
    logic        scl;
    logic        sda_oe;
    logic        ready;
    se_rd_t      rd;
    logic        done;
    logic        nack;
    logic        wi;
  } se_host_t;

  localparam logic [7:0] POLL_TOP = 8'(POLL_MAX - 1);

  se_host_t st_reg;
  se_host_t st_next;

  always_comb begin
    st_next          = st_reg;
    st_next.rd.valid = 1'b0;
    st_next.done     = 1'b0;
    case (st_reg.stage)
      ST_IDLE: begin
        st_next.ready = 1'b1;
        if (cmd_valid_i && st_reg.ready) begin
          st_next.ready = 1'b0;
          st_next.nack  = 1'b0;
          st_next.cmd   = cmd_i;
          st_next.stage = ST_START;
          st_next.seg   = SG_ADDR;
          st_next.ph    = PH_SETUP;
          st_next.polls = '0;
          st_next.fail  = 1'b0;
          st_next.wi    = !(cmd_i.op == OP_WRITE || cmd_i.op == OP_POLL);
          st_next.sh    = slave_byte(DEV_TYPE, cmd_i.strap,
                            (cmd_i.op == OP_CUR_READ) ? DIR_READ
                                                      : DIR_WRITE);
        end
      end
      ST_START: begin
        if (tick) begin
          st_next.ph = se_phase_t'(st_reg.ph + 2'h1);
          case (st_reg.ph)
            PH_SETUP: begin
              st_next.scl    = 1'b0;
              st_next.sda_oe = 1'b0;
            end
            PH_RISE:   st_next.scl    = 1'b1;
            PH_SAMPLE: st_next.sda_oe = 1'b1;
            default: begin
              st_next.scl   = 1'b0;
              st_next.stage = ST_XMIT;
              st_next.bitn  = '0;
            end
          endcase
        end
      end
      ST_XMIT: begin
        if (tick) begin
          st_next.ph = se_phase_t'(st_reg.ph + 2'h1);
          case (st_reg.ph)
            PH_SETUP: st_next.sda_oe = (st_reg.bitn != ACK_BIT)
                                       && !st_reg.sh[BYTE_W-1];
            PH_RISE:  st_next.scl = 1'b1;
            PH_SAMPLE: begin
              if (st_reg.bitn == ACK_BIT) begin
                st_next.ackd = !sda_s;
              end
            end
            default: begin
              st_next.scl = 1'b0;
              if (st_reg.bitn != ACK_BIT) begin
                st_next.sh   = {st_reg.sh[BYTE_W-2:0], 1'b0};
                st_next.bitn = st_reg.bitn + 4'h1;
              end else if (!st_reg.ackd) begin
                st_next.fail  = 1'b1;
                st_next.stage = ST_STOP;
              end else begin
                st_next.bitn = '0;
                case (st_reg.seg)
                  SG_ADDR: begin
                    if (st_reg.cmd.op == OP_POLL) begin
                      st_next.stage = ST_STOP;
                    end else if (st_reg.cmd.op == OP_CUR_READ) begin
                      st_next.stage = ST_RECV;
                      st_next.seg   = SG_READ;
                      st_next.left  = st_reg.cmd.len;
                    end else begin
                      st_next.seg = SG_WORD;
                      st_next.sh  = st_reg.cmd.word;
                    end
                  end
                  SG_WORD: begin
                    if (st_reg.cmd.op == OP_WRITE) begin
                      st_next.seg  = SG_DATA;
                      st_next.sh   = st_reg.cmd.wdata[BYTE_W-1:0];
                      st_next.left = (st_reg.cmd.len > PAGE_LAST)
                                     ? PAGE_LAST : st_reg.cmd.len;
                    end else begin
                      st_next.stage = ST_START;
                      st_next.seg   = SG_RADDR;
                      st_next.sh    = slave_byte(DEV_TYPE, st_reg.cmd.strap,
                                                 DIR_READ);
                    end
                  end
                  SG_DATA: begin
                    if (st_reg.left == '0) begin
                      st_next.stage = ST_STOP;
                    end else begin
                      st_next.left      = st_reg.left - 3'h1;
                      st_next.cmd.wdata = st_reg.cmd.wdata >> BYTE_W;
                      st_next.sh        = st_reg.cmd.wdata[2*BYTE_W-1:BYTE_W];
                    end
                  end
                  default: begin
                    st_next.stage = ST_RECV;
                    st_next.seg   = SG_READ;
                    st_next.left  = st_reg.cmd.len;
                  end
                endcase
              end
            end
          endcase
        end
      end
      ST_RECV: begin
        if (tick) begin
          st_next.ph = se_phase_t'(st_reg.ph + 2'h1);
          case (st_reg.ph)
            PH_SETUP: st_next.sda_oe = (st_reg.bitn == ACK_BIT)
                                       && (st_reg.left != '0);
            PH_RISE:  st_next.scl = 1'b1;
            PH_SAMPLE: begin
              if (st_reg.bitn != ACK_BIT) begin
                st_next.sh = {st_reg.sh[BYTE_W-2:0], sda_s};
              end
            end
            default: begin
              st_next.scl = 1'b0;
              if (st_reg.bitn != ACK_BIT) begin
                st_next.bitn = st_reg.bitn + 4'h1;
                if (st_reg.bitn == LAST_BIT) begin
                  st_next.rd.valid = 1'b1;
                  st_next.rd.data  = st_reg.sh;
                end
              end else if (st_reg.left == '0) begin
                st_next.stage = ST_STOP;
              end else begin
                st_next.left = st_reg.left - 3'h1;
                st_next.bitn = '0;
              end
            end
          endcase
        end
      end
      ST_STOP: begin
        if (tick) begin
          st_next.ph = se_phase_t'(st_reg.ph + 2'h1);
          case (st_reg.ph)
            PH_SETUP: begin
              st_next.scl    = 1'b0;
              st_next.sda_oe = 1'b1;
            end
            PH_RISE:   st_next.scl    = 1'b1;
            PH_SAMPLE: st_next.sda_oe = 1'b0;
            default: begin
              if (st_reg.cmd.op == OP_POLL && st_reg.fail
                  && st_reg.polls != POLL_TOP) begin
                st_next.polls = st_reg.polls + 8'h01;
                st_next.fail  = 1'b0;
                st_next.stage = ST_START;
                st_next.seg   = SG_ADDR;
                st_next.sh    = slave_byte(DEV_TYPE, st_reg.cmd.strap,
                                           DIR_WRITE);
              end else begin
                st_next.stage = ST_IDLE;
                st_next.done  = 1'b1;
                st_next.nack  = st_reg.fail;
                st_next.ready = 1'b1;
                st_next.wi    = 1'b1;
              end
            end
          endcase
        end
      end
      default: st_next.stage = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_reg       <= '0;
      st_reg.stage <= ST_IDLE;
      st_reg.scl   <= 1'b1;
      st_reg.wi    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cmd_ready_o     = st_reg.ready;
  assign rd_o            = st_reg.rd;
  assign done_o          = st_reg.done;
  assign nack_o          = st_reg.nack;
  assign scl_o           = st_reg.scl;
  assign sda_o           = 1'b0;
  assign sda_oe_o        = st_reg.sda_oe;
  assign write_inhibit_o = st_reg.wi;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sda_data_stable_a: assert property (
    $changed(st_reg.sda_oe)
    && (st_reg.stage == ST_XMIT || st_reg.stage == ST_RECV)
    |-> !st_reg.scl && !$past(st_reg.scl))
    else $error("sda moved while scl high during data");

  start_shape_a: assert property (
    tick && st_reg.stage == ST_START && st_reg.ph == PH_SAMPLE
    |=> st_reg.scl && st_reg.sda_oe && $past(!st_reg.sda_oe))
    else $error("start not a falling sda with scl high");

  stop_shape_a: assert property (
    tick && st_reg.stage == ST_STOP && st_reg.ph == PH_SAMPLE
    |=> st_reg.scl && !st_reg.sda_oe && $past(st_reg.sda_oe))
    else $error("stop not a rising sda with scl high");

  ack_release_a: assert property (
    st_reg.stage == ST_XMIT && st_reg.bitn == ACK_BIT
    && st_reg.ph != PH_SETUP |-> !st_reg.sda_oe)
    else $error("master held sda during slave acknowledge");

  last_read_nack_a: assert property (
    st_reg.stage == ST_RECV && st_reg.bitn == ACK_BIT
    && st_reg.ph == PH_SAMPLE |-> st_reg.sda_oe == (st_reg.left != '0))
    else $error("wrong master acknowledge on read byte");

  nack_stop_a: assert property (
    tick && st_reg.stage == ST_XMIT && st_reg.ph == PH_FALL
    && st_reg.bitn == ACK_BIT && !st_reg.ackd
    |=> st_reg.stage == ST_STOP && st_reg.fail)
    else $error("no stop after missing acknowledge");

  dir_bit_a: assert property (
    st_reg.stage == ST_START && st_reg.ph == PH_SETUP
    |-> st_reg.sh[0] == (st_reg.seg == SG_RADDR
                         || st_reg.cmd.op == OP_CUR_READ))
    else $error("direction bit does not match the operation");

  page_limit_a: assert property (
    st_reg.stage != ST_IDLE && st_reg.seg == SG_DATA
    |-> st_reg.left <= PAGE_LAST)
    else $error("page write longer than four bytes");

  ready_idle_a: assert property (
    st_reg.ready |-> st_reg.stage == ST_IDLE && st_reg.scl)
    else $error("ready while a transfer is running");
endmodule

// file: tb/se_mem_model.sv
// behavioural two-wire memory that answers the bus master
module se_mem_model #(
  parameter logic [3:0] DEV_TYPE = 4'h5,  // value is arbitrary
  parameter logic [2:0] STRAP    = 3'h6,
  parameter int         PROG_NS  = 6000
) (
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic write_inhibit_i,
  output logic      pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [7:0] pbuf [4];
  logic [7:0] ptr, sh, tx;
  logic [3:0] pmask;
  logic [2:0] mode;
  logic       busy, rd, mack;
  int         cnt;
  ////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3C;
    ptr = 8'h00;
    mode = 3'h0;
    cnt = 0;
    busy = 1'b0;
    pmask = 4'h0;
    pull_o = 1'b0;
  end
  task automatic commit();
    #(PROG_NS);
    for (int i = 0; i < 4; i++)
      if (pmask[i]) mem[{ptr[7:2], 2'(i)}] = pbuf[i];
    busy = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // start: ignored while programming
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    mode = busy ? 3'h0 : 3'h1;
    cnt = -1;
  end
  // stop: standby, programming after write data
  always @(posedge sda_i) if (scl_i === 1'b1) begin
    if (mode == 3'h3 && pmask != 4'h0 && !write_inhibit_i) begin
      busy = 1'b1;
      fork
        commit();
      join_none
    end
    mode = 3'h0;
    pull_o = 1'b0;
  end
  always @(posedge scl_i) if (mode != 3'h0) begin
    if (mode != 3'h4 && cnt < 8) sh = {sh[6:0], sda_i};
    if (mode == 3'h4 && cnt == 8) mack = (sda_i === 1'b0);
  end
  // line changes only after scl falls
  always @(negedge scl_i) if (mode != 3'h0) begin
    cnt++;
    if (cnt == 8) begin
      if (mode == 3'h4) pull_o = 1'b0;
      else if (mode == 3'h1) begin
        pull_o = (sh[7:1] == {DEV_TYPE, STRAP});
        rd = sh[0];
        if (!pull_o) mode = 3'h0;
      end else if (mode == 3'h2) begin
        ptr = sh;
        pmask = 4'h0;
        mode = 3'h3;
        pull_o = 1'b1;
      end else begin
        pbuf[ptr[1:0]] = sh;
        pmask[ptr[1:0]] = 1'b1;
        ptr[1:0] = ptr[1:0] + 2'h1;
        pull_o = 1'b1;
      end
    end else if (cnt == 9) begin
      pull_o = 1'b0;
      cnt = 0;
      if (mode == 3'h1) mode = rd ? 3'h4 : 3'h2;
      else if (mode == 3'h4 && !mack) mode = 3'h0;
      if (mode == 3'h4) begin
        tx = mem[ptr];
        ptr = ptr + 8'h01;
      end
    end
    if (mode == 3'h4 && cnt < 8) pull_o = !tx[7 - cnt];
  end
endmodule

// file: tb/se_host_tb.sv
// self-checking bench for the two-wire memory bus master
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
  err_total++; $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module se_host_tb
  import se_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_i, rstn_i, cmd_valid_i, cmd_ready_o, done_o, nack_o;
  logic       scl_o, sda_oe_o, write_inhibit_o, pull, sda_od;
  wire        sda_w;
  se_cmd_t    cmd_i;
  se_rd_t     rd_o;
  int         err_total, tests_run;
  logic [7:0] got [$];
  ////////////////////////////////////////////////////////////////////////
  // open drain with pull-up: low only where a driver pulls its level low
  assign sda_w = !((sda_oe_o && !sda_od) || pull);
  // both ends use device type code 5: the master by its default, the memory set explicitly
  se_host #(.QUARTER(8), .POLL_MAX(4)) dut (
    .clk_i           (clk_i),
    .rstn_i          (rstn_i),
    .cmd_valid_i     (cmd_valid_i),
    .cmd_i           (cmd_i),
    .cmd_ready_o     (cmd_ready_o),
    .rd_o            (rd_o),
    .done_o          (done_o),
    .nack_o          (nack_o),
    .scl_o           (scl_o),
    .sda_i           (sda_w),
    .sda_o           (sda_od),
    .sda_oe_o        (sda_oe_o),
    .write_inhibit_o (write_inhibit_o)
  );
  se_mem_model #(.DEV_TYPE(4'h5), .STRAP(3'h6)) mem (
    .scl_i           (scl_o),
    .sda_i           (sda_w),
    .write_inhibit_i (write_inhibit_o),
    .pull_o          (pull)
  );
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic run(input se_op_t op, input logic [2:0] st,
                     input logic [7:0] w, input logic [2:0] len,
                     input logic [31:0] wd);
    int   n;
    logic wi_exp;
    n = 0;
    wi_exp = !(op == OP_WRITE || op == OP_POLL);
    got.delete();
    while (cmd_ready_o !== 1'b1) @(posedge clk_i);
    cmd_i       <= '{op: op, strap: st, word: w, len: len, wdata: wd};
    cmd_valid_i <= 1'b1;
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    @(posedge clk_i);
    `CHK("inhibit", wi_exp, write_inhibit_o)
    while (done_o !== 1'b1 && n < 6000) begin
      @(posedge clk_i);
      n++;
      if (rd_o.valid === 1'b1) got.push_back(rd_o.data);
    end
    `CHK("done", 1'b1, done_o)
  endtask
  task automatic chk_rd(input logic [7:0] e [$]);
    `CHK("rd_count", e.size(), got.size())
    for (int i = 0; i < e.size() && i < got.size(); i++)
      `CHK("rd_byte", e[i], got[i])
  endtask
  ////////////////////////////////////////////////////////////////////////
  // four-byte page from an odd start, wrap inside the page
  task automatic t_page;
    run(OP_WRITE, 3'h6, 8'h0D, 3'h3, 32'h44332211);
    `CHK("wr_nack", 1'b0, nack_o)
    run(OP_POLL, 3'h6, 8'h00, 3'h0, 32'h0);
    `CHK("poll_nack", 1'b0, nack_o)
    run(OP_RAND_READ, 3'h6, 8'h0C, 3'h3, 32'h0);
    `CHK("rr_nack", 1'b0, nack_o)
    chk_rd('{8'h44, 8'h11, 8'h22, 8'h33});
    $display("test page done");
  endtask
  // bus ignored while programming, top wrap, current address
  task automatic t_busy;
    run(OP_WRITE, 3'h6, 8'hFF, 3'h0, 32'h0000005A);
    run(OP_CUR_READ, 3'h6, 8'h00, 3'h0, 32'h0);
    `CHK("busy_nack", 1'b1, nack_o)
    run(OP_POLL, 3'h6, 8'h00, 3'h0, 32'h0);
    `CHK("poll_nack", 1'b0, nack_o)
    run(OP_RAND_READ, 3'h6, 8'hFF, 3'h1, 32'h0);
    chk_rd('{8'h5A, 8'h3C});
    run(OP_CUR_READ, 3'h6, 8'h00, 3'h0, 32'h0);
    chk_rd('{8'h3D});
    $display("test busy done");
  endtask
  // wrong strap bits get no answer and write nothing
  task automatic t_miss;
    run(OP_WRITE, 3'h2, 8'h40, 3'h0, 32'h00000099);
    `CHK("wr_miss", 1'b1, nack_o)
    run(OP_POLL, 3'h7, 8'h00, 3'h0, 32'h0);
    `CHK("poll_miss", 1'b1, nack_o)
    run(OP_RAND_READ, 3'h6, 8'h40, 3'h0, 32'h0);
    chk_rd('{8'h7C});
    $display("test miss done");
  endtask
  // over-long page request is cut to four bytes, next location untouched
  task automatic t_clamp;
    run(OP_WRITE, 3'h6, 8'h80, 3'h6, 32'hD4C3B2A1);
    `CHK("clamp_nack", 1'b0, nack_o)
    run(OP_POLL, 3'h6, 8'h00, 3'h0, 32'h0);
    `CHK("clamp_poll", 1'b0, nack_o)
    run(OP_RAND_READ, 3'h6, 8'h80, 3'h4, 32'h0);
    chk_rd('{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hB8});
    $display("test clamp done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    err_total = 0;
    tests_run = 0;
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_page();
    t_busy();
    t_miss();
    t_clamp();
    close_out();
  end
  initial begin
    #1000000;
    err_total++;
    close_out();
  end
endmodule
